//--- hdl/ldpwm_top.sv
// dual channel dimming engine: digital pattern follower and embedded pwm
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a channel sees a digital pattern only once its input has been both under 0.8 V and over 4.0 V.
// - the pattern counts only while its rising edges are at least 1 ms apart and the channel has no fault.
// - in digital mode, with a valid pattern and a high input the driver is enabled and the pmos is on, else both off.
// - the embedded engine runs only while the input lies between the 0% and the 100% level.
// - in embedded mode the input level becomes a 10-bit duty code.
// - the duty code rises linearly with the input, about 10% at 1.26 V.
// - in embedded mode the pmos output follows the generated pwm waveform.
// - the pwm period is 7.4e-8 or 7.4e-7 seconds per ohm of the range resistor, high or low range.
// - a fault holds the pmos output off while the embedded timebase and mode selection keep running.
// - in the high range each fault type is reported with its own duty cycle on the report pin.
// - in the high range the voltage loop is off and the overvoltage comparator is on.
// - in the low range a fault holds the report pin raised until it clears.
// - in the low range the voltage loop is enabled next to the current loop.
// - whatever dimming mode runs gates both the switching driver and the pmos driver.
// - an input under the low threshold gives zero duty.
module ldpwm_top #(
  parameter logic [16:0] DIG_MIN_CYC   = ldpwm_pkg::DIG_MIN_CYC,
  parameter logic [20:0] DIG_IDLE_CYC  = ldpwm_pkg::DIG_IDLE_CYC,
  parameter logic [19:0] FAULT_PER_CYC = ldpwm_pkg::FAULT_PER_CYC
) (
  input  wire logic                                      mclk_i,
  input  wire logic                                      reset_i,
  input  wire ldpwm_pkg::ldpwm_in_t [ldpwm_pkg::NCH-1:0] chan_i,
  output ldpwm_pkg::ldpwm_out_t     [ldpwm_pkg::NCH-1:0] chan_o,
  output ldpwm_pkg::ldpwm_mode_t    [ldpwm_pkg::NCH-1:0] mode_o
);
  import ldpwm_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      // level classification, independent per channel
      wire [12:0] lvl     = chan_i[g].level_mv;
      wire        is_low  = lvl < LOW_THR_MV;
      wire        is_high = lvl > HIGH_THR_MV;
      wire        is_mid  = !is_low && !is_high;
      wire        in_win  = (lvl > ZERO_MV) && (lvl < FULL_MV);
      wire        fault   = chan_i[g].fault;

      // digital pattern tracking
      logic        high_d_ff;
      logic        seen_low_ff;
      logic        seen_high_ff;
      logic        fast_ff;
      logic [16:0] ecnt_ff;
      logic [20:0] idle_ff;
      logic        nxt_high_d;
      logic        nxt_seen_low;
      logic        nxt_seen_high;
      logic        nxt_fast;
      logic [16:0] nxt_ecnt;
      logic [20:0] nxt_idle;

      wire rise      = is_high && !high_d_ff;
      wire idle_out  = idle_ff >= DIG_IDLE_CYC;
      wire too_fast  = ecnt_ff < DIG_MIN_CYC;

      assign nxt_high_d    = is_high;
      // a level parked between thresholds long enough ends the pattern
      assign nxt_idle      = !is_mid ? 21'h0 : (idle_out ? idle_ff : idle_ff + 21'h1);
      // a fresh crossing beats the idle clear that lands in the same cycle
      assign nxt_seen_low  = (idle_out ? 1'b0 : seen_low_ff) | is_low;
      assign nxt_seen_high = (idle_out ? 1'b0 : seen_high_ff) | is_high;
      // interval counter saturates at the limit, so a slow pattern never wraps it
      assign nxt_ecnt      = rise ? 17'h0 : (too_fast ? ecnt_ff + 17'h1 : ecnt_ff);
      // first rising edge has no interval to judge, so only later edges can mark fast
      assign nxt_fast      = idle_out ? 1'b0
                           : (rise && seen_high_ff) ? too_fast : fast_ff;

      wire dig_valid = seen_low_ff && seen_high_ff && !fast_ff && !fault;

      // swing flags
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          high_d_ff    <= 1'b0;
          seen_low_ff  <= 1'b0;
          seen_high_ff <= 1'b0;
        end else begin
          high_d_ff    <= nxt_high_d;
          seen_low_ff  <= nxt_seen_low;
          seen_high_ff <= nxt_seen_high;
        end
      end

      // edge spacing and idle timers
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          fast_ff <= 1'b0;
          ecnt_ff <= 17'h0;
          idle_ff <= 21'h0;
        end else begin
          fast_ff <= nxt_fast;
          ecnt_ff <= nxt_ecnt;
          idle_ff <= nxt_idle;
        end
      end

      // embedded period timebase: 1024 phase steps per period
      logic [15:0] step_ff;
      logic [9:0]  ph_ff;
      logic [15:0] nxt_step;
      logic [9:0]  nxt_ph;
      wire  [15:0] slen      = step_len(chan_i[g].res_ohm, chan_i[g].high_rng);
      wire         step_done = step_ff >= slen - 16'h1;
      wire         boundary  = step_done && (ph_ff == DUTY_MAX);

      // resistor changes take effect within one step, never mid-compare glitch
      assign nxt_step = step_done ? STEP_RST : step_ff + 16'h1;
      assign nxt_ph   = step_done ? ph_ff + 10'h1 : ph_ff;

      // duty code and mode latched only at period end
      logic [9:0]  duty_ff;
      logic [9:0]  nxt_duty;
      ldpwm_mode_t mode_ff;
      ldpwm_mode_t nxt_mode;
      ldpwm_mode_t sel_mode;
      wire  [9:0]  duty_now = lvl_to_duty(lvl);

      assign sel_mode = dig_valid ? MODE_DIG
                      : (in_win ? MODE_EMB : MODE_OFF);
      assign nxt_mode = boundary ? sel_mode : mode_ff;
      assign nxt_duty = boundary ? duty_now : duty_ff;

      // period timebase
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          step_ff <= STEP_RST;
          ph_ff   <= DUTY_RST;
        end else begin
          step_ff <= nxt_step;
          ph_ff   <= nxt_ph;
        end
      end

      // period-end latches
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          duty_ff <= DUTY_RST;
          mode_ff <= MODE_OFF;
        end else begin
          duty_ff <= nxt_duty;
          mode_ff <= nxt_mode;
        end
      end

      // output gating
      logic dim_on;
      wire  pwm_on = ph_ff < duty_ff;

      always_comb begin
        dim_on = 1'b0;
        unique case (mode_ff)
          MODE_OFF: dim_on = 1'b0;
          MODE_DIG: dim_on = dig_valid && is_high;
          MODE_EMB: dim_on = pwm_on && in_win;
          default:  dim_on = 1'b0;
        endcase
      end

      logic pmos_ff;
      logic gate_ff;
      logic vloop_ff;
      logic ovc_ff;
      logic nxt_pmos;
      logic nxt_gate;
      logic nxt_vloop;
      logic nxt_ovc;
      wire  nxt_on = dim_on && !fault;

      assign nxt_pmos  = nxt_on;
      assign nxt_gate  = nxt_on;
      assign nxt_vloop = chan_i[g].low_rng;
      assign nxt_ovc   = chan_i[g].high_rng;

      // dimming drivers
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          pmos_ff <= 1'b0;
          gate_ff <= 1'b0;
        end else begin
          pmos_ff <= nxt_pmos;
          gate_ff <= nxt_gate;
        end
      end

      // loop selection follows the range decode one cycle late
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          vloop_ff <= 1'b0;
          ovc_ff   <= 1'b0;
        end else begin
          vloop_ff <= nxt_vloop;
          ovc_ff   <= nxt_ovc;
        end
      end

      logic rpt;
      ldpwm_frpt #(
        .FAULT_PER_CYC (FAULT_PER_CYC)
      ) u_frpt (
        .mclk_i     (mclk_i),
        .reset_i    (reset_i),
        .fault_i    (fault),
        .type_i     (chan_i[g].fault_type),
        .high_rng_i (chan_i[g].high_rng),
        .low_rng_i  (chan_i[g].low_rng),
        .rpt_o      (rpt)
      );

      assign chan_o[g].pmos_on   = pmos_ff;
      assign chan_o[g].gate_en   = gate_ff;
      assign chan_o[g].fault_rpt = rpt;
      assign chan_o[g].vloop_en  = vloop_ff;
      assign chan_o[g].ov_cmp_en = ovc_ff;
      assign mode_o[g]           = mode_ff;
    end
  endgenerate
endmodule
`default_nettype wire

//--- pkg/ldpwm_pkg.sv
// shared constants, types and helpers for the led dimming pwm engine
package ldpwm_pkg;

  localparam int NCH    = 2;
  localparam int DUTY_W = 10;
  localparam int MV_W   = 13;
  localparam int RES_W  = 17;

  // timing base
  localparam int CLK_HZ      = 100_000_000;
  localparam int DIG_FMAX_HZ = 1000;
  localparam int DIG_IDLE_MS = 20;
  localparam int FAULT_PER_MS = 10;
  localparam logic [16:0] DIG_MIN_CYC   = 17'(CLK_HZ / DIG_FMAX_HZ);
  localparam logic [20:0] DIG_IDLE_CYC  = 21'(DIG_IDLE_MS * (CLK_HZ / 1000));
  localparam logic [19:0] FAULT_PER_CYC = 20'(FAULT_PER_MS * (CLK_HZ / 1000));

  // input thresholds in millivolts
  localparam logic [12:0] LOW_THR_MV  = 13'h0320;
  localparam logic [12:0] HIGH_THR_MV = 13'h0FA0;
  localparam logic [12:0] ZERO_MV     = 13'h03E8;
  localparam logic [12:0] FULL_MV     = 13'h0E10;
  localparam logic [21:0] SPAN_MV     = 22'h000A28;
  localparam logic [9:0]  DUTY_MAX    = 10'h3FF;
  localparam logic [9:0]  DUTY_RST    = 10'h000;

  // period = coef * R; at 100 MHz coef is 7.4 (high) or 74 (low) cycles per ohm
  localparam logic [23:0] PER_COEF_X10 = 24'h00004A;
  localparam logic [23:0] HR_DIV       = 24'h002800;
  localparam logic [23:0] LR_DIV       = 24'h000400;
  localparam logic [15:0] STEP_RST     = 16'h0000;

  localparam logic [2:0] FT_S2G   = 3'h0;
  localparam logic [2:0] FT_OVFB  = 3'h1;
  localparam logic [2:0] FT_OTEMP = 3'h2;
  localparam logic [2:0] FT_OVFBH = 3'h3;
  localparam logic [2:0] FT_OCUR  = 3'h4;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_DIG = 2'b01,
    MODE_EMB = 2'b10
  } ldpwm_mode_t;

  typedef struct packed {
    logic [12:0] level_mv;
    logic        high_rng;
    logic        low_rng;
    logic [16:0] res_ohm;
    logic        fault;
    logic [2:0]  fault_type;
  } ldpwm_in_t;

  typedef struct packed {
    logic pmos_on;
    logic gate_en;
    logic fault_rpt;
    logic vloop_en;
    logic ov_cmp_en;
  } ldpwm_out_t;

  function automatic logic [9:0] lvl_to_duty(input logic [12:0] mv);
    logic [21:0] d;
    d = 22'h0;
    if (mv <= ZERO_MV) begin
      return DUTY_RST;
    end
    if (mv >= FULL_MV) begin
      return DUTY_MAX;
    end
    d = (22'(mv - ZERO_MV) * 22'(DUTY_MAX)) / SPAN_MV;
    return d[9:0];
  endfunction

  function automatic logic [15:0] step_len(input logic [16:0] res, input logic high);
    logic [23:0] p;
    logic [23:0] q;
    p = 24'(res) * PER_COEF_X10;
    q = high ? (p / HR_DIV) : (p / LR_DIV);
    if (q == 24'h0) begin
      q = 24'h1;
    end
    return q[15:0];
  endfunction

  function automatic logic [9:0] fault_duty(input logic [2:0] ft);
    logic [9:0] r;
    case (ft)
      FT_S2G:   r = 10'h0CD;
      FT_OVFB:  r = 10'h19A;
      FT_OTEMP: r = 10'h266;
      FT_OVFBH: r = 10'h333;
      FT_OCUR:  r = 10'h3E6;
      default:  r = 10'h200;
    endcase
    return r;
  endfunction

endpackage

//--- hdl/ldpwm_frpt.sv
// fault report waveform generator for one channel
`timescale 1ns/1ps
`default_nettype none
module ldpwm_frpt #(
  parameter logic [19:0] FAULT_PER_CYC = ldpwm_pkg::FAULT_PER_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       fault_i,
  input  wire logic [2:0] type_i,
  input  wire logic       high_rng_i,
  input  wire logic       low_rng_i,
  output logic            rpt_o
);
  import ldpwm_pkg::*;

  logic [19:0] cnt_ff;
  logic [19:0] nxt_cnt;
  logic        rpt_ff;
  logic        nxt_rpt;
  wire  [31:0] cnt_scaled = {2'b00, cnt_ff, 10'h000};
  wire  [31:0] thr_scaled = 32'(FAULT_PER_CYC) * 32'(fault_duty(type_i));
  wire         in_high    = cnt_scaled < thr_scaled;

  // counter rests at zero so each fault starts with a fresh high phase
  assign nxt_cnt = (!fault_i || cnt_ff >= FAULT_PER_CYC - 20'h1) ? 20'h0 : cnt_ff + 20'h1;
  assign nxt_rpt = fault_i & ((high_rng_i & in_high) | low_rng_i);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_ff <= 20'h0;
      rpt_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rpt_ff <= nxt_rpt;
    end
  end

  assign rpt_o = rpt_ff;
endmodule
`default_nettype wire

//--- bench/ldpwm_chk.sv
// port assertions for the dual channel dimming engine
`timescale 1ns/1ps
`default_nettype none
module ldpwm_chk (
  input wire logic                                      mclk_i,
  input wire logic                                      reset_i,
  input wire ldpwm_pkg::ldpwm_in_t   [ldpwm_pkg::NCH-1:0] chan_i,
  input wire ldpwm_pkg::ldpwm_out_t  [ldpwm_pkg::NCH-1:0] chan_o,
  input wire ldpwm_pkg::ldpwm_mode_t [ldpwm_pkg::NCH-1:0] mode_o
);
  import ldpwm_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    property p_gate;
      chan_o[k].gate_en == chan_o[k].pmos_on;
    endproperty
    a_gate: assert property (p_gate) else $error("driver enable differs from pmos");
    property p_flt;
      chan_i[k].fault |=> !chan_o[k].pmos_on;
    endproperty
    a_flt: assert property (p_flt) else $error("pmos on under fault");
    property p_low;
      chan_i[k].level_mv < LOW_THR_MV |=> !chan_o[k].pmos_on;
    endproperty
    a_low: assert property (p_low) else $error("pmos on below low level");
    // between full level and high threshold no mode may light the string
    property p_gap;
      chan_i[k].level_mv >= FULL_MV && chan_i[k].level_mv <= HIGH_THR_MV |=> !chan_o[k].pmos_on;
    endproperty
    a_gap: assert property (p_gap) else $error("pmos on in dead band");
    // the release edge still shows reset values, so judge only from the next edge on
    property p_loop;
      !reset_i |=> chan_o[k].vloop_en == $past(chan_i[k].low_rng)
        && chan_o[k].ov_cmp_en == $past(chan_i[k].high_rng);
    endproperty
    a_loop: assert property (p_loop) else $error("loop select wrong");
    property p_off;
      mode_o[k] == MODE_OFF |=> !chan_o[k].pmos_on;
    endproperty
    a_off: assert property (p_off) else $error("pmos on in off mode");
    property p_lrpt;
      chan_i[k].low_rng && !chan_i[k].high_rng |=> chan_o[k].fault_rpt == $past(chan_i[k].fault);
    endproperty
    a_lrpt: assert property (p_lrpt) else $error("low range report wrong");
    property p_hrpt;
      $rose(chan_i[k].fault) && chan_i[k].high_rng && !chan_i[k].low_rng |=> chan_o[k].fault_rpt;
    endproperty
    a_hrpt: assert property (p_hrpt) else $error("high range report missing");
    property p_nrpt;
      !chan_i[k].fault |=> !chan_o[k].fault_rpt;
    endproperty
    a_nrpt: assert property (p_nrpt) else $error("report without fault");
  end
endmodule
bind ldpwm_top ldpwm_chk i_chk (.mclk_i(mclk_i), .reset_i(reset_i), .chan_i(chan_i),
  .chan_o(chan_o), .mode_o(mode_o));
`default_nettype wire

//--- bench/ldpwm_src.sv
// external dimming source: square pattern swinging rail to rail
`timescale 1ns/1ps
`default_nettype none
module ldpwm_src (
  input  wire logic        mclk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] half_i,
  input  wire logic [12:0] idle_i,
  output var  logic [12:0] level_o
);
  logic [15:0] cnt_ff;
  always @(posedge mclk_i) begin
    if (!run_i) begin
      cnt_ff  <= 16'h0000;
      level_o <= idle_i;
    end else if (cnt_ff >= half_i - 16'h0001) begin
      // a shortened half period must not run the counter round its whole range
      cnt_ff  <= 16'h0000;
      // swing past both thresholds so the pattern is recognisable
      level_o <= (level_o > 13'h0FA0) ? 13'h0000 : 13'h1004;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- bench/ldpwm_top_bench.sv
// self-checking bench for the dual channel dimming engine
`timescale 1ns/1ps
`default_nettype none
module ldpwm_top_bench;
  import ldpwm_pkg::*;
  typedef struct {
    logic [12:0] mv;
    logic [16:0] res;
    logic        hi;
    ldpwm_mode_t md;
    logic [15:0] on;
    int          win;
  } ldpwm_row_t;
  // level, resistor, range, mode, on cycles in one window of one period
  ldpwm_row_t rows [9] = '{
    '{13'h04EC, 17'h00000, 1'b1, MODE_EMB, 16'h0066, 1024},
    '{13'h08FC, 17'h00000, 1'b1, MODE_EMB, 16'h01FF, 1024},
    '{13'h0E0F, 17'h00000, 1'b1, MODE_EMB, 16'h03FE, 1024},
    '{13'h03E9, 17'h00000, 1'b1, MODE_EMB, 16'h0000, 1024},
    '{13'h03E8, 17'h00000, 1'b1, MODE_OFF, 16'h0000, 1024},
    '{13'h0E10, 17'h00000, 1'b1, MODE_OFF, 16'h0000, 1024},
    '{13'h01F4, 17'h00000, 1'b1, MODE_OFF, 16'h0000, 1024},
    '{13'h08FC, 17'h00115, 1'b1, MODE_EMB, 16'h03FE, 2048},
    '{13'h08FC, 17'h0002A, 1'b0, MODE_EMB, 16'h05FD, 3072}};
  logic [15:0] duty [6] = '{16'h00CD, 16'h019A, 16'h0266, 16'h0333, 16'h03E6, 16'h0200};
  logic                  mclk_i  = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  run     = 1'b0;
  logic [15:0]           half    = 16'h003C;
  logic [12:0]           lvl;
  logic [15:0]           c;
  logic                  p;
  ldpwm_in_t   [NCH-1:0] ci;
  ldpwm_in_t   [NCH-1:0] cin;
  ldpwm_out_t  [NCH-1:0] co;
  ldpwm_mode_t [NCH-1:0] mo;
  int                    n_errors = 0;
  int                    compares = 0;
  int                    cyc      = 0;
  always #5 mclk_i = ~mclk_i;
  always_comb begin
    cin = ci;
    cin[0].level_mv = lvl;
  end
  ldpwm_src i_src (.mclk_i(mclk_i), .run_i(run), .half_i(half), .idle_i(ci[0].level_mv),
    .level_o(lvl));
  ldpwm_top #(.DIG_MIN_CYC(17'h00032), .DIG_IDLE_CYC(21'h0000C8), .FAULT_PER_CYC(20'h00400))
    i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .chan_i(cin), .chan_o(co), .mode_o(mo));
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // counts pmos (sel 0) or report (sel 1) high cycles
  task automatic count(input int ch, input bit sel, input int n);
    c = 16'h0000;
    repeat (n) begin
      @(negedge mclk_i);
      c = c + 16'((sel ? co[ch].fault_rpt : co[ch].pmos_on) === 1'b1);
    end
  endtask
  // mode only changes at a period end, so allow a few periods
  task automatic dig_wait();
    int i;
    i = 0;
    while (mo[0] !== MODE_DIG && i < 4000) begin
      @(negedge mclk_i);
      i++;
    end
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    ci = '0;
    ci[1].high_rng = 1'b1;
    ci[1].fault = 1'b1;
    ci[1].fault_type = FT_OCUR;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_v(16'({co, mo}), 16'h0000, "reset outputs");
    @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge mclk_i);
      ci[0].level_mv <= rows[i].mv;
      ci[0].res_ohm <= rows[i].res;
      ci[0].high_rng <= rows[i].hi;
      ci[0].low_rng <= !rows[i].hi;
      tick(2 * rows[i].win);
      chk_v(16'(mo[0]), 16'(rows[i].md), "mode");
      count(0, 1'b0, rows[i].win);
      chk_v(c, rows[i].on, "duty");
    end
    @(posedge mclk_i);
    ci[0].res_ohm <= 17'h00000;
    ci[0].high_rng <= 1'b1;
    ci[0].low_rng <= 1'b0;
    run <= 1'b1;
    dig_wait();
    chk_v(16'(mo[0]), 16'(MODE_DIG), "digital mode");
    p = lvl > HIGH_THR_MV;
    repeat (400) begin
      @(negedge mclk_i);
      chk_v(16'(co[0].pmos_on), 16'(p), "follow");
      p = lvl > HIGH_THR_MV;
    end
    @(posedge mclk_i);
    half <= 16'h000A;
    tick(100);
    count(0, 1'b0, 300);
    chk_v(c, 16'h0000, "fast pattern");
    @(posedge mclk_i);
    half <= 16'h003C;
    // let a slow interval clear the fast flag before the pattern is trusted again
    tick(300);
    dig_wait();
    count(0, 1'b0, 240);
    chk_v(c, 16'h0078, "pattern duty");
    @(posedge mclk_i);
    ci[0].fault <= 1'b1;
    count(0, 1'b0, 200);
    chk_v(c, 16'h0000, "fault pmos");
    for (int t = 0; t < 6; t++) begin
      @(posedge mclk_i);
      ci[1].fault <= 1'b0;
      ci[1].fault_type <= 3'(t);
      tick(3);
      @(posedge mclk_i);
      ci[1].fault <= 1'b1;
      tick(2);
      count(1, 1'b1, 1024);
      chk_v(c, duty[t], "fault duty");
    end
    chk_v(16'({co[1].vloop_en, co[1].ov_cmp_en}), 16'h0001, "high loops");
    @(posedge mclk_i);
    ci[1].high_rng <= 1'b0;
    ci[1].low_rng <= 1'b1;
    tick(3);
    chk_v(16'({co[1].fault_rpt, co[1].vloop_en, co[1].ov_cmp_en}), 16'h0006, "low rpt");
    @(posedge mclk_i);
    ci[1].fault <= 1'b0;
    tick(2);
    chk_v(16'(co[1].fault_rpt), 16'h0000, "low clear");
    conclude();
  end
endmodule
`default_nettype wire
